// *** rtl/rss_pkg.sv ***
// Constants, register layout and types shared by the rail step sequencer
package rss_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] RSS_OFS_DELAY_LOW = 8'h20;
  localparam logic [7:0] RSS_OFS_LAST_FACTOR = 8'h21;
  localparam logic [7:0] RSS_OFS_BUCK_ASSIGN = 8'h22;
  localparam logic [7:0] RSS_RST_DELAY_LOW = 8'h00;
  localparam logic [7:0] RSS_RST_LAST_FACTOR = 8'h00;
  localparam logic [7:0] RSS_RST_BUCK_ASSIGN = 8'h98;
  localparam int RSS_FACTOR_BIT = 7;
  localparam int RSS_LAST_GAP_BIT = 0;
  localparam int RSS_FIRST_BUCK_LSB = 0;
  localparam int RSS_SECOND_BUCK_LSB = 4;
  localparam int RSS_FIELD_W = 4;

  // ****************************************************************
  // Step numbering
  // ****************************************************************
  localparam logic [3:0] RSS_STEP_FIRST = 4'h1;
  localparam logic [3:0] RSS_STEP_LAST = 4'ha;
  localparam logic [3:0] RSS_STEP_LOW_REG_MAX = 4'h8;
  localparam logic [3:0] RSS_BUCK_STEP_MIN = 4'h3;
  localparam logic [3:0] RSS_BUCK_STEP_MAX = 4'ha;
  localparam logic [3:0] RSS_SEAL_STEP_MAX = 4'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RSS_CLK_MHZ = 250;
  localparam int RSS_GAP_SHORT_US = 2000;
  localparam int RSS_GAP_LONG_US = 5000;
  localparam int RSS_GAP_SHORT_CYC = RSS_GAP_SHORT_US * RSS_CLK_MHZ;
  localparam int RSS_GAP_LONG_CYC = RSS_GAP_LONG_US * RSS_CLK_MHZ;
  localparam int RSS_DOWN_FACTOR = 10;
  localparam int RSS_TMR_W = 24;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] delay_low;
    logic factor;
    logic last_gap;
    logic [7:0] buck_assign;
  } rss_regs_t;

  typedef enum logic [2:0] {
    RSS_IDLE,
    RSS_UP_STROBE,
    RSS_UP_WAIT,
    RSS_DN_STROBE,
    RSS_DN_WAIT
  } rss_state_t;

  // Field code places a rail at this step only for codes 3h..Ah
  function automatic logic rss_step_owned(input logic [3:0] code, input logic [3:0] step);
    return (code == step) && (code >= RSS_BUCK_STEP_MIN) && (code <= RSS_BUCK_STEP_MAX);
  endfunction

  function automatic logic rss_code_valid(input logic [3:0] code);
    return (code >= RSS_BUCK_STEP_MIN) && (code <= RSS_BUCK_STEP_MAX);
  endfunction

endpackage

// *** rtl/rss_regfile.sv ***
// Write-protected timing and step-assignment registers
`timescale 1ns/1ps
module rss_regfile
  import rss_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wr_unlock,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output rss_regs_t regs
);

  rss_regs_t regs_ff;
  rss_regs_t nxt_regs;

  // ****************************************************************
  // Next values
  // ****************************************************************
  always_comb begin
    nxt_regs = regs_ff;
    if (reg_we && wr_unlock) begin // [R12]
      case (reg_addr)
        RSS_OFS_DELAY_LOW: begin
          nxt_regs.delay_low = reg_wdata; // [R1]
        end
        RSS_OFS_LAST_FACTOR: begin
          nxt_regs.factor = reg_wdata[RSS_FACTOR_BIT]; // [R3]
          nxt_regs.last_gap = reg_wdata[RSS_LAST_GAP_BIT]; // [R2]
        end
        RSS_OFS_BUCK_ASSIGN: begin
          nxt_regs.buck_assign = reg_wdata; // [R5]
        end
        default: begin
          nxt_regs = regs_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regs_ff.delay_low <= RSS_RST_DELAY_LOW; // [R8]
      regs_ff.factor <= RSS_RST_LAST_FACTOR[RSS_FACTOR_BIT]; // [R9]
      regs_ff.last_gap <= RSS_RST_LAST_FACTOR[RSS_LAST_GAP_BIT]; // [R9]
      regs_ff.buck_assign <= RSS_RST_BUCK_ASSIGN; // [R7]
    end else if (ce) begin
      regs_ff <= nxt_regs;
    end
  end

  assign regs = regs_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_LOCKED_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
    (reg_we && !wr_unlock) |=> (regs_ff == $past(regs_ff)))
    else $error("register changed on a locked write");

  AST_UNLOCKED_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
    (ce && reg_we && wr_unlock && reg_addr == RSS_OFS_BUCK_ASSIGN) |=> (regs_ff.buck_assign == $past(reg_wdata)))
    else $error("unlocked write to step assignment not stored");

endmodule

// *** rtl/rss_gap_timer.sv ***
// Down-counter that times one gap between sequence steps
`timescale 1ns/1ps
module rss_gap_timer
  import rss_pkg::*;
#(
  parameter int TMR_W = RSS_TMR_W
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [TMR_W-1:0] load_cycles,
  output logic done
);

  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_cycles;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - TMR_W'(1);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done while the last counted cycle is held
  assign done = (cnt_ff == TMR_W'(1));

endmodule

// *** rtl/rss_sequencer.sv ***
// Power-rail step sequencer with programmable gaps and core buck slots
//
// Contract
// (R1) Gaps one to eight chosen by first register
// (R2) Gap nine chosen by second register bit 0
// (R3) Factor bit multiplies power-down gaps by ten
// (R4) Factor bit never alters power-up gaps
// (R5) Buck fields 3h..Ah enable at step three..ten
// (R6) Other field codes leave the rail unsequenced
// (R7) Step assignment register resets to 98h
// (R8) First delay register resets to zero
// (R9) Second register resets zero, bits 6-1 zero
// (R10) Steps one, two only while seal clear
// (R11) Ascend on power-up, descend on power-down
// (R12) Writes accepted only when unlocked
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int GAP_SHORT_CYC = RSS_GAP_SHORT_CYC,
  parameter int GAP_LONG_CYC = RSS_GAP_LONG_CYC
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wr_unlock,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] rd_data_ff,
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic freshness_seal_flag,
  output logic [9:0] step_strobe_ff,
  output logic step_dir_up_ff,
  output logic first_core_buck_en_ff,
  output logic second_core_buck_en_ff,
  output logic busy_ff,
  output logic powered_ff
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  rss_regs_t regs;
  logic [7:0] nxt_rd_data;

  rss_regfile u_regfile (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .wr_unlock(wr_unlock),
    .reg_we(reg_we),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .regs(regs)
  );

  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (reg_re) begin
      case (reg_addr)
        RSS_OFS_DELAY_LOW: begin
          nxt_rd_data = regs.delay_low;
        end
        RSS_OFS_LAST_FACTOR: begin
          nxt_rd_data = {regs.factor, 6'h00, regs.last_gap}; // [R9]
        end
        RSS_OFS_BUCK_ASSIGN: begin
          nxt_rd_data = regs.buck_assign;
        end
        default: begin
          nxt_rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff <= 8'h00;
    end else if (ce) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ****************************************************************
  // Gap selection
  // ****************************************************************
  logic [3:0] first_buck_step_field;
  logic [3:0] second_buck_step_field;
  assign first_buck_step_field = regs.buck_assign[RSS_FIRST_BUCK_LSB +: RSS_FIELD_W];
  assign second_buck_step_field = regs.buck_assign[RSS_SECOND_BUCK_LSB +: RSS_FIELD_W];

  // Select bit of the gap between step lower and lower+1
  function automatic logic gap_long(input logic [3:0] lower, input rss_regs_t r);
    if (lower <= RSS_STEP_LOW_REG_MAX) begin
      return r.delay_low[3'(lower - 4'h1)]; // [R1]
    end
    return r.last_gap; // [R2]
  endfunction

  // Cycle count of one gap, optionally scaled for power-down
  function automatic logic [RSS_TMR_W-1:0] gap_cycles(input logic long_sel, input logic scale);
    logic [RSS_TMR_W-1:0] base;
    base = long_sel ? RSS_TMR_W'(GAP_LONG_CYC) : RSS_TMR_W'(GAP_SHORT_CYC);
    if (scale) begin
      return RSS_TMR_W'(base * RSS_TMR_W'(RSS_DOWN_FACTOR)); // [R3]
    end
    return base; // [R4]
  endfunction

  // ****************************************************************
  // Step state machine
  // ****************************************************************
  rss_state_t state_ff;
  rss_state_t nxt_state;
  logic [3:0] step_ff;
  logic [3:0] nxt_step;
  logic [9:0] nxt_strobe;
  logic nxt_dir_up;
  logic nxt_first_en;
  logic nxt_second_en;
  logic nxt_busy;
  logic nxt_powered;
  logic tmr_load;
  logic [RSS_TMR_W-1:0] tmr_cycles;
  logic tmr_done;

  rss_gap_timer #(
    .TMR_W(RSS_TMR_W)
  ) u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .load(tmr_load),
    .load_cycles(tmr_cycles),
    .done(tmr_done)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_strobe = 10'h000;
    nxt_dir_up = step_dir_up_ff;
    nxt_first_en = first_core_buck_en_ff;
    nxt_second_en = second_core_buck_en_ff;
    nxt_powered = powered_ff;
    tmr_load = 1'b0;
    tmr_cycles = '0;
    case (state_ff)
      RSS_IDLE: begin
        if (power_up_req && !powered_ff) begin
          nxt_state = RSS_UP_STROBE;
          nxt_step = RSS_STEP_FIRST; // [R11]
          nxt_dir_up = 1'b1;
        end else if (power_down_req && powered_ff) begin
          nxt_state = RSS_DN_STROBE;
          nxt_step = RSS_STEP_LAST; // [R11]
          nxt_dir_up = 1'b0;
        end
      end
      RSS_UP_STROBE: begin
        // Steps one and two run only while the seal is intact
        if (step_ff > RSS_SEAL_STEP_MAX || !freshness_seal_flag) begin // [R10]
          nxt_strobe[4'(step_ff - 4'h1)] = 1'b1;
        end
        if (rss_step_owned(first_buck_step_field, step_ff)) begin // [R5] [R6]
          nxt_first_en = 1'b1;
        end
        if (rss_step_owned(second_buck_step_field, step_ff)) begin // [R5] [R6]
          nxt_second_en = 1'b1;
        end
        if (step_ff == RSS_STEP_LAST) begin
          nxt_state = RSS_IDLE;
          nxt_powered = 1'b1;
        end else begin
          tmr_load = 1'b1;
          tmr_cycles = gap_cycles(gap_long(step_ff, regs), 1'b0) - RSS_TMR_W'(1); // [R1] [R2] [R4]
          nxt_state = RSS_UP_WAIT;
        end
      end
      RSS_UP_WAIT: begin
        if (tmr_done) begin
          nxt_step = step_ff + 4'h1; // [R11]
          nxt_state = RSS_UP_STROBE;
        end
      end
      RSS_DN_STROBE: begin
        // A broken seal keeps steps one and two, so backup rails stay on
        if (step_ff > RSS_SEAL_STEP_MAX || !freshness_seal_flag) begin // [R10]
          nxt_strobe[4'(step_ff - 4'h1)] = 1'b1;
        end
        if (rss_step_owned(first_buck_step_field, step_ff)) begin // [R6] [R11]
          nxt_first_en = 1'b0;
        end
        if (rss_step_owned(second_buck_step_field, step_ff)) begin // [R6] [R11]
          nxt_second_en = 1'b0;
        end
        if (step_ff == RSS_STEP_FIRST) begin
          nxt_state = RSS_IDLE;
          nxt_powered = 1'b0;
        end else begin
          tmr_load = 1'b1;
          tmr_cycles = gap_cycles(gap_long(step_ff - 4'h1, regs), regs.factor) - RSS_TMR_W'(1); // [R3]
          nxt_state = RSS_DN_WAIT;
        end
      end
      RSS_DN_WAIT: begin
        if (tmr_done) begin
          nxt_step = step_ff - 4'h1; // [R11]
          nxt_state = RSS_DN_STROBE;
        end
      end
      default: begin
        nxt_state = RSS_IDLE;
      end
    endcase
    nxt_busy = (nxt_state != RSS_IDLE);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= RSS_IDLE;
      step_ff <= RSS_STEP_FIRST;
      step_strobe_ff <= 10'h000;
      step_dir_up_ff <= 1'b0;
      first_core_buck_en_ff <= 1'b0;
      second_core_buck_en_ff <= 1'b0;
      busy_ff <= 1'b0;
      powered_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      step_strobe_ff <= nxt_strobe;
      step_dir_up_ff <= nxt_dir_up;
      first_core_buck_en_ff <= nxt_first_en;
      second_core_buck_en_ff <= nxt_second_en;
      busy_ff <= nxt_busy;
      powered_ff <= nxt_powered;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic up_load;
  logic dn_load;
  assign up_load = ce && tmr_load && (state_ff == RSS_UP_STROBE);
  assign dn_load = ce && tmr_load && (state_ff == RSS_DN_STROBE);

  AST_UP_GAP_LOW: assert property (@(posedge clock) disable iff (sys_rst) // [R1]
    (up_load && step_ff <= RSS_STEP_LOW_REG_MAX) |->
      (tmr_cycles == (regs.delay_low[3'(step_ff - 4'h1)] ? RSS_TMR_W'(GAP_LONG_CYC - 1)
                                                          : RSS_TMR_W'(GAP_SHORT_CYC - 1))))
    else $error("power-up gap does not follow first delay register");

  AST_UP_GAP_LAST: assert property (@(posedge clock) disable iff (sys_rst) // [R2]
    (up_load && step_ff == 4'h9) |->
      (tmr_cycles == (regs.last_gap ? RSS_TMR_W'(GAP_LONG_CYC - 1) : RSS_TMR_W'(GAP_SHORT_CYC - 1))))
    else $error("gap after step nine does not follow its select bit");

  AST_DOWN_FACTOR: assert property (@(posedge clock) disable iff (sys_rst) // [R3]
    (dn_load && regs.factor) |->
      (tmr_cycles == RSS_TMR_W'(gap_cycles(gap_long(step_ff - 4'h1, regs), 1'b0) * 10 - 1)))
    else $error("power-down gap not scaled by ten");

  AST_UP_UNSCALED: assert property (@(posedge clock) disable iff (sys_rst) // [R4]
    (up_load && regs.factor) |->
      (tmr_cycles == RSS_TMR_W'(GAP_SHORT_CYC - 1) || tmr_cycles == RSS_TMR_W'(GAP_LONG_CYC - 1)))
    else $error("power-up gap scaled by factor bit");

  sequence s_first_buck_step;
    ce && state_ff == RSS_UP_STROBE && step_ff == first_buck_step_field;
  endsequence

  AST_BUCK_ON: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
    (s_first_buck_step and rss_code_valid(first_buck_step_field)) |=> first_core_buck_en_ff)
    else $error("first buck not enabled at its step");

  AST_BUCK_UNSEQ: assert property (@(posedge clock) disable iff (sys_rst) // [R6]
    (!rss_code_valid(second_buck_step_field) && state_ff != RSS_IDLE) |=> $stable(second_core_buck_en_ff))
    else $error("unsequenced buck changed during a sequence");

  AST_RD_RESERVED: assert property (@(posedge clock) disable iff (sys_rst) // [R9]
    (ce && reg_re && reg_addr == RSS_OFS_LAST_FACTOR) |=> (rd_data_ff[6:1] == 6'h00))
    else $error("reserved bits read nonzero");

  AST_SEAL: assert property (@(posedge clock) disable iff (sys_rst) // [R10]
    freshness_seal_flag |=> (step_strobe_ff[1:0] == 2'b00))
    else $error("step one or two strobed with seal broken");

  sequence s_up_step_done;
    ce && state_ff == RSS_UP_WAIT && tmr_done;
  endsequence

  AST_UP_ORDER: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
    s_up_step_done |=> (state_ff == RSS_UP_STROBE && step_ff == $past(step_ff) + 4'h1))
    else $error("power-up did not advance one step");

  AST_DN_ORDER: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
    (ce && state_ff == RSS_DN_WAIT && tmr_done) |=> (step_ff == $past(step_ff) - 4'h1))
    else $error("power-down did not descend one step");

endmodule

// *** sim/rss_rail_model.sv ***
// Model of the rail enable inputs that watches the sequencer outputs
`timescale 1ns/1ps
module rss_rail_model (
  input wire logic clock,
  input wire logic [9:0] step_strobe_ff,
  input wire logic first_core_buck_en_ff,
  input wire logic second_core_buck_en_ff,
  input wire logic busy_ff
);
  int cyc = 0;
  int stamp [10];
  int en_chg [2];
  int order [$];
  logic busy_q = 1'b0;
  logic [1:0] rail_on = 2'h0;

  // ****************************************************************
  // Log strobe times, step order and rail switching per sequence
  // ****************************************************************
  always @(posedge clock) begin
    cyc++;
    if (busy_ff === 1'b1 && busy_q !== 1'b1) begin
      order.delete();
      foreach (stamp[k]) stamp[k] = -1;
      en_chg[0] = -1;
      en_chg[1] = -1;
    end
    for (int k = 0; k < 10; k++) begin
      if (step_strobe_ff[k] === 1'b1) begin
        stamp[k] = cyc;
        order.push_back(k + 1);
      end
    end
    if (first_core_buck_en_ff !== rail_on[0]) en_chg[0] = cyc;
    if (second_core_buck_en_ff !== rail_on[1]) en_chg[1] = cyc;
    busy_q <= busy_ff;
    rail_on <= {second_core_buck_en_ff, first_core_buck_en_ff};
  end
endmodule

// *** sim/rss_sequencer_tb.sv ***
// Self-checking testbench of the rail step sequencer
`timescale 1ns/1ps
module rss_sequencer_tb
  import rss_pkg::*;
;
  localparam int SH = 4;
  localparam int LG = 10;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic wr_unlock = 1'b0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic power_up_req = 1'b0;
  logic power_down_req = 1'b0;
  logic freshness_seal_flag = 1'b0;
  logic [7:0] rd_data_ff;
  logic [9:0] step_strobe_ff;
  logic step_dir_up_ff, first_core_buck_en_ff, second_core_buck_en_ff, busy_ff, powered_ff;
  logic [7:0] r20 = 8'h00;
  logic [7:0] r21 = 8'h00;
  int fail_count = 0;
  int checked = 0;

  always #2 clock = ~clock;

  rss_sequencer #(.GAP_SHORT_CYC(SH), .GAP_LONG_CYC(LG)) dut (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .wr_unlock(wr_unlock), .reg_we(reg_we),
    .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data_ff(rd_data_ff),
    .power_up_req(power_up_req), .power_down_req(power_down_req),
    .freshness_seal_flag(freshness_seal_flag), .step_strobe_ff(step_strobe_ff),
    .step_dir_up_ff(step_dir_up_ff), .first_core_buck_en_ff(first_core_buck_en_ff),
    .second_core_buck_en_ff(second_core_buck_en_ff), .busy_ff(busy_ff), .powered_ff(powered_ff)
  );

  rss_rail_model rails (
    .clock(clock), .step_strobe_ff(step_strobe_ff), .first_core_buck_en_ff(first_core_buck_en_ff),
    .second_core_buck_en_ff(second_core_buck_en_ff), .busy_ff(busy_ff)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
    @(negedge clock);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    wr_unlock = unl;
    @(negedge clock);
    reg_we = 1'b0;
    wr_unlock = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_re = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_re = 1'b0;
    chk(what, {24'h0, rd_data_ff}, {24'h0, exp});
  endtask

  function automatic int gap(input int s);
    if (s <= 8) return r20[s-1] ? LG : SH;
    return r21[0] ? LG : SH;
  endfunction

  task automatic run_seq(input logic up);
    int n;
    @(negedge clock);
    power_up_req = up;
    power_down_req = ~up;
    @(negedge clock);
    power_up_req = 1'b0;
    power_down_req = 1'b0;
    n = 0;
    while (busy_ff !== 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    // The rail model logs the last strobe one edge after busy falls
    @(negedge clock);
    chk("sequence finished", {31'h0, n < 2000}, 32'h1);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd_chk("low delays reset", RSS_OFS_DELAY_LOW, 8'h00);
    rd_chk("last delay reset", RSS_OFS_LAST_FACTOR, 8'h00);
    rd_chk("buck assign reset", RSS_OFS_BUCK_ASSIGN, 8'h98);
    wr(RSS_OFS_BUCK_ASSIGN, 8'h55, 1'b0);
    rd_chk("locked write", RSS_OFS_BUCK_ASSIGN, 8'h98);
    wr(RSS_OFS_LAST_FACTOR, 8'hff, 1'b1);
    rd_chk("reserved bits", RSS_OFS_LAST_FACTOR, 8'h81);
    rd_chk("unmapped read", 8'h23, 8'h00);
    ce = 1'b0;
    wr(RSS_OFS_DELAY_LOW, 8'h3c, 1'b1);
    ce = 1'b1;
    rd_chk("frozen write", RSS_OFS_DELAY_LOW, 8'h00);
  endtask

  task automatic t_up_down();
    r20 = 8'ha5;
    r21 = 8'h81;
    wr(RSS_OFS_DELAY_LOW, r20, 1'b1);
    wr(RSS_OFS_LAST_FACTOR, r21, 1'b1);
    wr(RSS_OFS_BUCK_ASSIGN, 8'h3a, 1'b1);
    run_seq(1'b1);
    chk("up step count", rails.order.size(), 10);
    for (int i = 0; i < rails.order.size(); i++) chk("up order", rails.order[i], i + 1);
    for (int s = 1; s <= 9; s++) chk("up gap", rails.stamp[s] - rails.stamp[s-1], gap(s));
    chk("second buck on", rails.en_chg[1], rails.stamp[2]);
    chk("first buck on", rails.en_chg[0], rails.stamp[9]);
    chk("powered", {31'h0, powered_ff}, 32'h1);
    chk("direction up", {31'h0, step_dir_up_ff}, 32'h1);
    run_seq(1'b0);
    chk("down step count", rails.order.size(), 10);
    for (int i = 0; i < rails.order.size(); i++) chk("down order", rails.order[i], 10 - i);
    for (int s = 10; s >= 2; s--) chk("down gap", rails.stamp[s-2] - rails.stamp[s-1], gap(s-1) * 10);
    chk("second buck off", rails.en_chg[1], rails.stamp[2]);
    chk("first buck off", rails.en_chg[0], rails.stamp[9]);
    chk("powered off", {31'h0, powered_ff}, 32'h0);
    chk("direction down", {31'h0, step_dir_up_ff}, 32'h0);
  endtask

  task automatic t_seal();
    r21 = 8'h01;
    wr(RSS_OFS_LAST_FACTOR, r21, 1'b1);
    freshness_seal_flag = 1'b1;
    run_seq(1'b1);
    chk("sealed step one", rails.stamp[0], -1);
    chk("sealed step two", rails.stamp[1], -1);
    run_seq(1'b0);
    chk("sealed down step one", rails.stamp[0], -1);
    chk("sealed down step two", rails.stamp[1], -1);
    for (int s = 10; s >= 4; s--) chk("unscaled gap", rails.stamp[s-2] - rails.stamp[s-1], gap(s-1));
    freshness_seal_flag = 1'b0;
  endtask

  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      wr(RSS_OFS_BUCK_ASSIGN, {c[3:0], c[3:0]}, 1'b1);
      for (int d = 1; d >= 0; d--) begin
        run_seq(d[0]);
        if (c >= 3 && c <= 10) begin
          chk("first buck step", rails.en_chg[0], rails.stamp[c-1]);
          chk("second buck step", rails.en_chg[1], rails.stamp[c-1]);
        end else begin
          chk("first buck untouched", rails.en_chg[0], -1);
          chk("second buck untouched", rails.en_chg[1], -1);
        end
      end
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_regs();
    t_up_down();
    t_seal();
    t_codes();
    end_sim();
  end

  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
endmodule
